// ===== rtl/sac_top.sv
// Purpose: Conversion control for a 12-bit successive approximation ADC.
// Assumes: AXI4-Lite master, comparator and trigger arrive as async pins.
// Notes: Registers CTRL, CLKDIV, STATUS, RESULT; reading RESULT clears done.
//
// Overview of operation
// - Twelve-bit result, up to one million samples.
// - Binary search from MSB down to LSB.
// - Conversion clock eighteen times sample rate, 1-18 MHz.
// - Start by software bit or hardware trigger.
// - Continuous mode works with trigger unconnected.
// - Wait ten microseconds after power-up or wake.
// - Done flag and output held until read.
// - Done output serves as interrupt or DMA request.
// - Single select: one conversion per trigger.
// - Continuous results move by DMA unaided.
// - Single-ended or differential input by configuration.
`timescale 1ns/100ps
module sac_top
   import sac_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic hw_trigger,
   input wire logic cmp_in,
   output logic [RES_BITS-1:0] dac_code,
   output logic sample_en,
   output logic diff_sel,
   output logic analog_power,
   output logic conv_done
);
   localparam logic [WAKE_W-1:0] WAKE_M1 = WAKE_W'(WAKE_CYCLES - 1);
   localparam logic [DIV_W-1:0] DIV_LO = DIV_W'(DIV_MIN);
   localparam logic [DIV_W-1:0] DIV_HI = DIV_W'(DIV_MAX);

   sac_conv_if #(.RES_W(RES_BITS)) cv ();

   logic [CTRL_W-1:0] ctrl_reg;
   logic [DIV_W-1:0] clkdiv_reg, div_cnt_reg, div_eff;
   logic [WAKE_W-1:0] wake_cnt_reg;
   logic [RES_BITS-1:0] result_reg;
   logic ready_reg, run_reg, start_reg, done_reg, ovr_reg;
   logic trig_s1_reg, trig_s2_reg, trig_s3_reg;
   logic cmp_s1_reg, cmp_s2_reg;
   logic awready_reg, bvalid_reg, arready_reg, rvalid_reg;
   logic [1:0] bresp_reg, rresp_reg;
   logic [31:0] rdata_reg, rd_word;
   logic rd_ok;
   logic wr_fire, rd_fire, wr_ctrl, wr_div, wr_stat, rd_result;
   logic sw_start, hw_start, req, start_next, tick, en, single, single_next;

   // Clamp the divider so the conversion clock stays within its range.
   function automatic logic [DIV_W-1:0] clamp_div(input logic [DIV_W-1:0] d);
      if (d < DIV_LO)
         clamp_div = DIV_LO;
      else if (d > DIV_HI)
         clamp_div = DIV_HI;
      else
         clamp_div = d;
   endfunction

   // Word address of a byte address.
   function automatic logic [ADDR_W-1:0] word_of(input logic [ADDR_W-1:0] a);
      word_of = {a[ADDR_W-1:2], 2'b00};
   endfunction

   // Bus handshake decode.
   assign wr_fire = awready_reg && s_axi_awvalid && s_axi_wvalid;
   assign rd_fire = arready_reg && s_axi_arvalid;
   assign wr_ctrl = wr_fire && s_axi_wstrb[0] && word_of(s_axi_awaddr) == OFF_CTRL;
   assign wr_div = wr_fire && s_axi_wstrb[0] && word_of(s_axi_awaddr) == OFF_CLKDIV;
   assign wr_stat = wr_fire && s_axi_wstrb[0] && word_of(s_axi_awaddr) == OFF_STATUS;
   assign rd_result = rd_fire && word_of(s_axi_araddr) == OFF_RESULT;

   // Start requests and the conversion clock tick.
   assign en = ctrl_reg[CTRL_EN];
   assign single = ctrl_reg[CTRL_SINGLE];
   // Mode as it stands after this edge, so a start written with a mode change obeys the new mode.
   assign single_next = wr_ctrl ? s_axi_wdata[CTRL_SINGLE] : single;
   assign sw_start = wr_ctrl && s_axi_wdata[CTRL_START];
   assign hw_start = ctrl_reg[CTRL_TRIG_EN] && trig_s2_reg && !trig_s3_reg;
   assign req = ready_reg && (sw_start || hw_start);
   assign start_next = ready_reg && !cv.busy && !start_reg && (req || run_reg);
   assign div_eff = clamp_div(clkdiv_reg);
   assign tick = cv.busy && (div_cnt_reg == div_eff - 8'h01);
   assign cv.start = start_reg;
   assign cv.tick = tick;
   assign cv.cmp = cmp_s2_reg;

   sac_sar #(.RES_W(RES_BITS)) u_sar (
      .aclk(aclk),
      .aresetn(aresetn),
      .cv(cv)
   );

   // Two-stage synchronisers for the pins; the third stage feeds the edge detect.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         trig_s1_reg <= 1'b0;
         trig_s2_reg <= 1'b0;
         trig_s3_reg <= 1'b0;
         cmp_s1_reg <= 1'b0;
         cmp_s2_reg <= 1'b0;
      end
      else
      begin
         trig_s1_reg <= hw_trigger;
         trig_s2_reg <= trig_s1_reg;
         trig_s3_reg <= trig_s2_reg;
         cmp_s1_reg <= cmp_in;
         cmp_s2_reg <= cmp_s1_reg;
      end
   end

   // Control registers written by software.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ctrl_reg <= CTRL_RST;
         clkdiv_reg <= CLKDIV_RST;
      end
      else
      begin
         if (wr_ctrl)
            ctrl_reg <= s_axi_wdata[CTRL_W-1:0] & ~(5'h01 << CTRL_START);
         if (wr_div)
            clkdiv_reg <= s_axi_wdata[DIV_W-1:0];
      end
   end

   // Wake-up wait after power-up or after leaving sleep.
   always_ff @(posedge aclk)
   begin
      if (!aresetn || !en)
      begin
         wake_cnt_reg <= '0;
         ready_reg <= 1'b0;
      end
      else if (!ready_reg && wake_cnt_reg == WAKE_M1)
         ready_reg <= 1'b1;
      else if (!ready_reg)
         wake_cnt_reg <= wake_cnt_reg + 10'h001;
   end

   // Continuous run flag; cleared by sleep or by choosing single mode.
   always_ff @(posedge aclk)
   begin
      if (!aresetn || !ready_reg || single_next)
         run_reg <= 1'b0;
      else if (req)
         run_reg <= 1'b1;
   end

   // Conversion start pulse and conversion clock divider.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         start_reg <= 1'b0;
         div_cnt_reg <= '0;
      end
      else
      begin
         start_reg <= start_next;
         div_cnt_reg <= (!cv.busy || tick) ? 8'h00 : div_cnt_reg + 8'h01;
      end
   end

   // Done flag held until the result is read; a new completion wins over the read.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         done_reg <= 1'b0;
         ovr_reg <= 1'b0;
         result_reg <= '0;
      end
      else
      begin
         if (cv.done)
            result_reg <= cv.result;
         if (cv.done)
            done_reg <= 1'b1;
         else if (rd_result)
            done_reg <= 1'b0;
         if (cv.done && done_reg && !rd_result)
            ovr_reg <= 1'b1;
         else if (wr_stat && s_axi_wdata[ST_OVR])
            ovr_reg <= 1'b0;
      end
   end

   // Read data selection.
   always_comb
   begin
      rd_word = 32'h0000_0000;
      rd_ok = 1'b1;
      if (word_of(s_axi_araddr) == OFF_CTRL)
         rd_word = {27'h0, ctrl_reg};
      else if (word_of(s_axi_araddr) == OFF_CLKDIV)
         rd_word = {24'h0, clkdiv_reg};
      else if (word_of(s_axi_araddr) == OFF_STATUS)
         rd_word = {28'h0, ovr_reg, ready_reg, cv.busy, done_reg};
      else if (word_of(s_axi_araddr) == OFF_RESULT)
         rd_word = {20'h0, result_reg};
      else
         rd_ok = 1'b0;
   end

   // Write channel: take address and data together, then respond.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         awready_reg <= 1'b0;
         bvalid_reg <= 1'b0;
         bresp_reg <= RESP_OKAY;
      end
      else
      begin
         awready_reg <= s_axi_awvalid && s_axi_wvalid && !awready_reg && !bvalid_reg;
         if (wr_fire)
         begin
            bvalid_reg <= 1'b1;
            bresp_reg <= (word_of(s_axi_awaddr) > OFF_RESULT) ? RESP_SLVERR : RESP_OKAY;
         end
         else if (s_axi_bready)
            bvalid_reg <= 1'b0;
      end
   end

   // Read channel: one read at a time, answer one cycle after acceptance.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         arready_reg <= 1'b0;
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
         rresp_reg <= RESP_OKAY;
      end
      else
      begin
         arready_reg <= s_axi_arvalid && !arready_reg && !rvalid_reg;
         if (rd_fire)
         begin
            rvalid_reg <= 1'b1;
            rdata_reg <= rd_word;
            rresp_reg <= rd_ok ? RESP_OKAY : RESP_SLVERR;
         end
         else if (s_axi_rready)
            rvalid_reg <= 1'b0;
      end
   end

   // Pin and bus outputs, all from flip-flops.
   assign s_axi_awready = awready_reg;
   assign s_axi_wready = awready_reg;
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;
   assign s_axi_arready = arready_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rdata = rdata_reg;
   assign s_axi_rresp = rresp_reg;
   assign dac_code = cv.dac_code;
   assign sample_en = cv.sample;
   assign diff_sel = ctrl_reg[CTRL_DIFF];
   assign analog_power = en;
   assign conv_done = done_reg;

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   AST_WAKE_WAIT: assert property ($rose(ready_reg) |-> $past(wake_cnt_reg) == WAKE_M1)
      else $error("Ready rose before the wake-up wait elapsed.");
   AST_NO_EARLY_START: assert property (start_reg |-> $past(ready_reg))
      else $error("Conversion started before wake-up completed.");
   AST_DONE_SET: assert property (cv.done |=> conv_done && result_reg == $past(cv.result))
      else $error("Completion did not raise done with the result.");
   AST_DONE_HOLD: assert property (conv_done && !rd_result && !cv.done |=> conv_done)
      else $error("Done dropped before the result was read.");
   AST_DONE_CLEAR: assert property (conv_done && rd_result && !cv.done |=> !conv_done)
      else $error("Done did not clear on result read.");
   AST_SINGLE_ONE: assert property (start_reg && !$past(run_reg) |-> $past(req))
      else $error("Conversion started without a request outside continuous mode.");
   AST_AUTO_RESTART: assert property (cv.done && run_reg && ready_reg && !wr_fire |=> start_reg)
      else $error("Continuous mode did not restart after completion.");
   AST_TICK_RATE: assert property (tick |=> !tick [*5])
      else $error("Conversion clock exceeds its maximum rate.");
   COV_SINGLE: cover property (single && start_reg ##[1:400] cv.done);
   COV_CONTINUOUS: cover property (run_reg && cv.done ##[1:400] cv.done);
   COV_HW_TRIG: cover property (hw_start && ready_reg ##1 start_reg);
   COV_OVERRUN: cover property ($rose(ovr_reg));
endmodule

// ===== common/sac_pkg.sv
// Purpose: Shared constants for the SAR conversion control block.
// Assumes: 100 MHz bus clock, 12-bit result, AXI4-Lite register access.
// Notes: Timing counts are derived from the times and the clock rate.
package sac_pkg;
   localparam int CLK_HZ = 100_000_000;
   localparam int RES_BITS = 12;
   localparam int CONV_TICKS = 18;
   localparam int SAMPLE_TICKS = CONV_TICKS - RES_BITS;
   localparam int CONV_CLK_MIN_HZ = 1_000_000;
   localparam int CONV_CLK_MAX_HZ = 18_000_000;
   localparam int DIV_W = 8;
   localparam int DIV_MIN = (CLK_HZ + CONV_CLK_MAX_HZ - 1) / CONV_CLK_MAX_HZ;
   localparam int DIV_MAX = CLK_HZ / CONV_CLK_MIN_HZ;
   localparam int WAKE_US = 10;
   localparam int WAKE_CYCLES = WAKE_US * (CLK_HZ / 1_000_000);
   localparam int WAKE_W = 10;
   localparam int ADDR_W = 4;
   // Register byte offsets.
   localparam logic [ADDR_W-1:0] OFF_CTRL = 4'h0;
   localparam logic [ADDR_W-1:0] OFF_CLKDIV = 4'h4;
   localparam logic [ADDR_W-1:0] OFF_STATUS = 4'h8;
   localparam logic [ADDR_W-1:0] OFF_RESULT = 4'hC;
   // Control field positions.
   localparam int CTRL_EN = 0;
   localparam int CTRL_START = 1;
   localparam int CTRL_SINGLE = 2;
   localparam int CTRL_DIFF = 3;
   localparam int CTRL_TRIG_EN = 4;
   localparam int CTRL_W = 5;
   localparam logic [CTRL_W-1:0] CTRL_RST = 5'h00;
   // Status field positions.
   localparam int ST_DONE = 0;
   localparam int ST_BUSY = 1;
   localparam int ST_READY = 2;
   localparam int ST_OVR = 3;
   localparam logic [DIV_W-1:0] CLKDIV_RST = 8'h06;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ===== common/sac_conv_if.sv
// Purpose: Carrier between the control top and the bit search engine.
// Assumes: One conversion in flight at a time.
// Notes: The tick marks one conversion clock period.
`timescale 1ns/100ps
interface sac_conv_if #(
   parameter int RES_W = 12
);
   logic start;
   logic tick;
   logic cmp;
   logic busy;
   logic done;
   logic sample;
   logic [RES_W-1:0] result;
   logic [RES_W-1:0] dac_code;
   modport ctrl (output start, tick, cmp, input busy, done, sample, result, dac_code);
   modport eng (input start, tick, cmp, output busy, done, sample, result, dac_code);
endinterface

// ===== rtl/sac_sar.sv
// Purpose: Binary search engine deciding result bits from MSB to LSB.
// Assumes: Comparator input is already synchronised; tick paced by top.
// Notes: One conversion is SAMPLE_TICKS sampling ticks plus one per bit.
`timescale 1ns/100ps
module sac_sar
   import sac_pkg::*;
#(
   parameter int RES_W = RES_BITS
)
(
   input wire logic aclk,
   input wire logic aresetn,
   sac_conv_if.eng cv
);
   typedef enum logic [1:0] {SAC_IDLE, SAC_SAMP, SAC_BITS} sac_eng_t;
   localparam logic [4:0] MSB_IDX = 5'(RES_W - 1);
   localparam logic [4:0] SAMP_LAST = 5'(CONV_TICKS - RES_W - 1);
   sac_eng_t state_reg, state_next;
   logic [4:0] cnt_reg, cnt_next;
   logic [RES_W-1:0] dac_reg, dac_next, res_reg, res_next, kept;
   logic done_reg, done_next, samp_reg;
   logic [4:0] tk_reg;

   function automatic logic [RES_W-1:0] bit_at(input logic [4:0] idx);
      bit_at = {{(RES_W-1){1'b0}}, 1'b1} << idx;
   endfunction

   // Keep the trial bit when the input is above the trial level.
   assign kept = cv.cmp ? dac_reg : (dac_reg & ~bit_at(cnt_reg));
   assign cv.busy = (state_reg != SAC_IDLE);
   assign cv.done = done_reg;
   assign cv.result = res_reg;
   assign cv.dac_code = dac_reg;
   assign cv.sample = samp_reg;

   // Sample for a fixed number of ticks, then decide one bit per tick.
   always_comb
   begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      dac_next = dac_reg;
      res_next = res_reg;
      done_next = 1'b0;
      case (state_reg)
         SAC_IDLE:
            if (cv.start)
            begin
               state_next = SAC_SAMP;
               cnt_next = 5'h00;
               dac_next = '0;
            end
         SAC_SAMP:
            if (cv.tick && cnt_reg == SAMP_LAST)
            begin
               state_next = SAC_BITS;
               cnt_next = MSB_IDX;
               dac_next = bit_at(MSB_IDX);
            end
            else if (cv.tick)
               cnt_next = cnt_reg + 5'h01;
         SAC_BITS:
            if (cv.tick && cnt_reg == 5'h00)
            begin
               state_next = SAC_IDLE;
               res_next = kept;
               done_next = 1'b1;
               dac_next = '0;
            end
            else if (cv.tick)
            begin
               cnt_next = cnt_reg - 5'h01;
               dac_next = kept | bit_at(cnt_reg - 5'h01);
            end
         default:
            state_next = SAC_IDLE;
      endcase
   end

   // State and datapath registers.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         state_reg <= SAC_IDLE;
         cnt_reg <= 5'h00;
         dac_reg <= '0;
         res_reg <= '0;
         done_reg <= 1'b0;
         samp_reg <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         dac_reg <= dac_next;
         res_reg <= res_next;
         done_reg <= done_next;
         samp_reg <= (state_next == SAC_SAMP);
      end
   end

   // Helper count of conversion ticks, read only by the checks.
   always_ff @(posedge aclk)
   begin
      if (!aresetn || state_reg == SAC_IDLE)
         tk_reg <= 5'h00;
      else if (cv.tick)
         tk_reg <= tk_reg + 5'h01;
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   AST_CONV_TICKS: assert property (done_reg |-> tk_reg == 5'(CONV_TICKS))
      else $error("Conversion did not take the expected number of ticks.");
   AST_MSB_FIRST: assert property ($rose(state_reg == SAC_BITS) |-> dac_reg == bit_at(MSB_IDX))
      else $error("Bit search did not start at the most significant bit.");
   AST_LSB_FROM_CMP: assert property (done_reg |-> res_reg[0] == $past(cv.cmp))
      else $error("Last result bit does not follow the comparator.");
endmodule

// ===== bench/sac_cmp_model.sv
// Purpose: Comparator and sample-hold model facing the conversion block.
// Assumes: The analog input sits half an LSB above the target code.
// Notes: The held value is the one present when sampling ends.
`timescale 1ns/100ps
module sac_cmp_model
   import sac_pkg::*;
(
   input wire logic aclk,
   input wire logic sample_en,
   input wire logic [RES_BITS-1:0] dac_code,
   input wire logic [RES_BITS-1:0] target,
   output logic cmp_out
);
   logic [RES_BITS-1:0] held_reg;
   // Track the input while sampling and hold it through the bit search.
   always @(posedge aclk)
   begin
      if (sample_en === 1'b1)
      begin
         held_reg <= target;
      end
   end
   // High while the held input is not below the trial code.
   assign cmp_out = (dac_code <= held_reg);
endmodule

// ===== bench/tb_top.sv
// Purpose: Self-checking bench for the conversion control block.
// Assumes: Comparator model on the analog side, bus tasks on AXI4-Lite.
// Notes: Drivers note expected answers; a monitor compares them in order.
`timescale 1ns/100ps
module tb_top
   import sac_pkg::*;
;
   typedef struct packed {logic [31:0] d; logic [31:0] m; logic [1:0] r;} sac_exp_t;
   localparam logic [31:0] EN = 32'h1 << CTRL_EN;
   localparam logic [31:0] START = 32'h1 << CTRL_START;
   localparam logic [31:0] SINGLE = 32'h1 << CTRL_SINGLE;
   localparam logic [31:0] DIFF = 32'h1 << CTRL_DIFF;
   localparam logic [31:0] TRIG = 32'h1 << CTRL_TRIG_EN;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [ADDR_W-1:0] awaddr = '0;
   logic [ADDR_W-1:0] araddr = '0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic hw_trigger = 1'b0;
   logic [31:0] wdata = '0;
   logic [31:0] rv = '0;
   logic [31:0] seed = 32'hB1767FEF;
   logic [RES_BITS-1:0] target = '0;
   logic awready, wready, bvalid, arready, rvalid, cmp_in, sample_en, diff_sel;
   logic analog_power, conv_done;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic [RES_BITS-1:0] dac_code;
   int miscompares = 0;
   int checks = 0;
   sac_exp_t rq[$];
   logic [1:0] bq[$];

   // Free-running 100 MHz clock.
   always #5 aclk = ~aclk;

   sac_top u_sac_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .hw_trigger(hw_trigger), .cmp_in(cmp_in),
      .dac_code(dac_code), .sample_en(sample_en), .diff_sel(diff_sel),
      .analog_power(analog_power), .conv_done(conv_done));

   sac_cmp_model u_sac_cmp_model (.aclk(aclk), .sample_en(sample_en),
      .dac_code(dac_code), .target(target), .cmp_out(cmp_in));

   // Prints the verdict and ends the run.
   task automatic final_report();
      if (miscompares == 0 && checks > 0)
      begin
         $display("TB: PASS");
      end
      else
      begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic bad(input string s);
      miscompares++;
      $display("mismatch at %0t: %s", $time, s);
   endtask

   task automatic chk(input logic ok, input string s);
      checks++;
      if (ok !== 1'b1)
      begin
         bad(s);
      end
   endtask

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h0);
   endfunction

   function automatic logic pick(input int s);
      logic [4:0] v;
      v = {conv_done, rvalid, arready, bvalid, awready & wready};
      return v[s];
   endfunction

   // Waits on negative edges until a design output is high, with a bound.
   task automatic wait_hi(input int s, input int lim, output int n);
      n = 0;
      do
      begin
         @(negedge aclk);
         n++;
      end
      while (pick(s) !== 1'b1 && n < lim);
      if (pick(s) !== 1'b1)
      begin
         bad("wait timed out");
         final_report();
      end
   endtask

   // One write: address and data together, held until taken.
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [1:0] r);
      int n;
      bq.push_back(r);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      wait_hi(0, 50, n);
      @(posedge aclk);
      awvalid <= 1'b0;
      wvalid <= 1'b0;
      wait_hi(1, 50, n);
      @(posedge aclk);
      bready <= 1'b0;
   endtask

   // One read; the answer is left in rv.
   task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] e, input logic [31:0] m,
                     input logic [1:0] r);
      int n;
      rq.push_back('{e, m, r});
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      wait_hi(2, 50, n);
      @(posedge aclk);
      arvalid <= 1'b0;
      wait_hi(3, 50, n);
      rv = rdata;
      @(posedge aclk);
      rready <= 1'b0;
   endtask

   // Compares each bus answer with the oldest note left by the driver.
   always @(posedge aclk)
   begin
      sac_exp_t e;
      if (rvalid === 1'b1 && rready)
      begin
         e = rq.pop_front();
         checks++;
         if ((rdata & e.m) !== e.d || rresp !== e.r)
         begin
            bad("read data or response");
         end
      end
      if (bvalid === 1'b1 && bready)
      begin
         checks++;
         if (bresp !== bq.pop_front())
         begin
            bad("write response");
         end
      end
   end

   // Main sequence.
   initial
   begin
      int n;
      logic [RES_BITS-1:0] want;
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      rd(OFF_CTRL, 32'h0, 32'hFFFFFFFF, RESP_OKAY);
      rd(OFF_CLKDIV, 32'h6, 32'hFFFFFFFF, RESP_OKAY);
      rd(OFF_STATUS, 32'h0, 32'hFFFFFFFF, RESP_OKAY);
      chk(analog_power === 1'b0 && conv_done === 1'b0, "outputs after reset");
      // Unaligned offsets fall on the last register word and are answered normally.
      rd(4'hE, 32'h0, 32'hFFFFFFFF, RESP_OKAY);
      wr(4'hF, 32'hFFFFFFFF, RESP_OKAY);
      // Power up in differential mode; a start during wake-up is dropped.
      wr(OFF_CTRL, EN | DIFF, RESP_OKAY);
      chk(analog_power === 1'b1 && diff_sel === 1'b1, "power and input select");
      wr(OFF_CTRL, EN | DIFF | START, RESP_OKAY);
      repeat (880) @(posedge aclk);
      rd(OFF_STATUS, 32'h0, 32'h7, RESP_OKAY);
      n = 0;
      rv = '0;
      while (rv[ST_READY] !== 1'b1 && n < 40)
      begin
         rd(OFF_STATUS, 32'h0, 32'h0, RESP_OKAY);
         n++;
      end
      chk(rv[ST_READY] === 1'b1, "ready after wake delay");
      // Software starts with end codes and random codes.
      for (int i = 0; i < 4; i++)
      begin
         seed = lfsr(seed);
         target <= (i == 0) ? 12'hFFF : (i == 1) ? 12'h000 : seed[11:0];
         wr(OFF_CTRL, EN | SINGLE | START | (i[0] ? DIFF : 32'h0), RESP_OKAY);
         wait_hi(4, 200, n);
         repeat (40) @(posedge aclk);
         chk(conv_done === 1'b1 && diff_sel === i[0], "done held until read");
         rd(OFF_STATUS, 32'h1 << ST_DONE, 32'h1 << ST_DONE, RESP_OKAY);
         rd(OFF_RESULT, {20'h0, target}, 32'hFFFFFFFF, RESP_OKAY);
         repeat (2) @(posedge aclk);
         chk(conv_done === 1'b0, "done cleared by read");
      end
      // Trigger edges, one conversion each.
      wr(OFF_CTRL, EN | SINGLE | TRIG, RESP_OKAY);
      for (int i = 0; i < 2; i++)
      begin
         seed = lfsr(seed);
         target <= seed[11:0];
         @(posedge aclk);
         hw_trigger <= 1'b1;
         repeat (4) @(posedge aclk);
         hw_trigger <= 1'b0;
         wait_hi(4, 200, n);
         rd(OFF_RESULT, {20'h0, target}, 32'hFFF, RESP_OKAY);
         repeat (300) @(posedge aclk);
         chk(conv_done === 1'b0, "one conversion per trigger");
      end
      // A slower conversion clock stretches the eighteen ticks to about 180 bus cycles.
      wr(OFF_CLKDIV, 32'hA, RESP_OKAY);
      rd(OFF_CLKDIV, 32'hA, 32'hFF, RESP_OKAY);
      wr(OFF_CTRL, EN | SINGLE | START, RESP_OKAY);
      wait_hi(4, 400, n);
      chk(n >= CONV_TICKS * 10 - 4 && n <= CONV_TICKS * 10 + 8, "conversion length");
      rd(OFF_RESULT, {20'h0, target}, 32'hFFF, RESP_OKAY);
      // Free running with the trigger idle; done alone paces the reads.
      seed = lfsr(seed);
      target <= seed[11:0];
      wr(OFF_CTRL, EN | START, RESP_OKAY);
      for (int i = 0; i < 4; i++)
      begin
         wait_hi(4, 300, n);
         want = target;
         seed = lfsr(seed);
         target <= seed[11:0];
         rd(OFF_RESULT, {20'h0, want}, 32'hFFF, RESP_OKAY);
         @(posedge aclk);
         chk(conv_done === 1'b0, "done cleared in free run");
      end
      // An unread result met by the next completion keeps done and raises overrun.
      wait_hi(4, 300, n);
      repeat (200) @(posedge aclk);
      rd(OFF_STATUS, 32'h9, (32'h1 << ST_OVR) | (32'h1 << ST_DONE), RESP_OKAY);
      wr(OFF_STATUS, 32'h1 << ST_OVR, RESP_OKAY);
      rd(OFF_STATUS, 32'h1 << ST_DONE, (32'h1 << ST_OVR) | (32'h1 << ST_DONE), RESP_OKAY);
      wr(OFF_CTRL, 32'h0, RESP_OKAY);
      chk(analog_power === 1'b0, "power off");
      final_report();
   end
endmodule
